// [design/sbl_loader.sv]
// Serial boot loader: autobaud scan, download protocol, rx byte FIFO
`timescale 1ns/1ps
// Functional notes
// R01 - Password frame 0x011, echo 0x001, check
// R02 - Address/length frame 0x012, echo 0x002, keep
// R03 - Instruction format flag must be one
// R04 - Data frames 0x013 echoed as 0x003
// R05 - Pack bytes into words, write SRAM
// R06 - Advance address until byte count reached
// R07 - Final step branches to loaded code
// R08 - All protocol data carried byte by byte
// R09 - Autobaud config: receive pins become GPIO
// R10 - Sample CAN level to detect bus
// R11 - First low input wins, CAN first
// R12 - Tick timer counts clocks for measurement
// R13 - Measure oscillator before baud measurement
// R14 - Run system clock from modulated PLL
// R15 - PLL multiplier follows oscillator band
// R16 - After measurement pins return to peripheral
// R17 - Then run standard download protocol
// R18 - Host keeps both lines high initially
// R19 - Host sends 0x00 byte for UART timing
// R20 - Time falling to rising UART edge
// R21 - Send 0x59 acknowledge, then UART protocol
// R22 - Half duplex, every item echoed
// R23 - Multi-byte fields sent MSB first
// R24 - CAN frames use 11-bit identifiers
// R25 - UART characters 8N1
// R26 - Clear timer first, hold count

// Byte FIFO with registered ready toward the source
module sbl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Filling side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // Draining side
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];         // Storage
  logic [AW-1:0]    wrPtr_q, wrPtr_d;    // Write pointer
  logic [AW-1:0]    rdPtr_q, rdPtr_d;    // Read pointer
  logic [AW:0]      cnt_q, cnt_d;        // Fill level
  logic             notFull_q, notFull_d;
  logic             push, pop;
  // Next pointers and fill level
  always_comb begin
    push      = inValid && notFull_q;
    pop       = outValid && outReady;
    wrPtr_d   = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d   = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    cnt_d     = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    notFull_d = cnt_d != (AW+1)'(DEPTH);
  end
  // Pointer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_q   <= '0;
      rdPtr_q   <= '0;
      cnt_q     <= '0;
      notFull_q <= 1'b0;
    end else begin
      wrPtr_q   <= wrPtr_d;
      rdPtr_q   <= rdPtr_d;
      cnt_q     <= cnt_d;
      notFull_q <= notFull_d;
    end
  end
  // Storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
  assign inReady  = notFull_q;
  assign outValid = cnt_q != '0;
  assign outData  = mem[rdPtr_q];
endmodule

// Boot controller top
module sbl_loader (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Boot configuration and receive pin levels
  input  wire logic [1:0]           bootCfg,
  input  wire logic                 canRxPin,
  input  wire logic                 uartRxPin,
  // Clock monitor and PLL
  input  wire logic                 oscValid,
  input  wire logic [15:0]          oscKhz,
  input  wire logic                 pllLocked,
  output logic [2:0]                pllMult,
  output logic                      sysClkPll,
  // Pin function and link setup
  output logic                      rxPinGpio,
  output logic                      busCan,
  output logic [15:0]               uartDivisor,
  output logic [31:0]               canTimeBase,
  // Received bytes from the selected controller
  input  wire sbl_pkg::sbl_item_type rxItem,
  input  wire logic                 rxValid,
  output logic                      rxReady,
  // Echo and acknowledge bytes
  output sbl_pkg::sbl_item_type     txItem,
  output logic                      txValid,
  input  wire logic                 txReady,
  // Stored password
  input  wire logic [63:0]          storedPassword,
  // SRAM write port
  output sbl_pkg::sbl_sram_type     sramWr,
  output logic                      sramValid,
  input  wire logic                 sramReady,
  // Completion
  output logic [31:0]               branchAddr,
  output logic                      branchGo,
  output logic                      bootFail
);
  import sbl_pkg::*;

  sbl_state_type st_q, st_d;             // Controller state
  sbl_item_type  fifoItem;               // Head of rx FIFO
  logic          fifoValid, pop;
  logic [31:0]   timer_q, timer_d;       // System tick timer
  logic [31:0]   cnt_q, cnt_d;           // Byte counter
  logic [55:0]   shift_q, shift_d;       // Header byte shifter
  logic [23:0]   pack_q, pack_d;         // Word packer
  logic [31:0]   addr_q, addr_d;         // Load address
  logic [31:0]   start_q, start_d;       // Start address
  logic [30:0]   len_q, len_d;           // Byte count
  logic          canLive_q, canLive_d;   // CAN bus seen idle high
  logic [2:0]    mul_q, mul_d;
  logic          pll_q, pll_d;
  logic          gpio_q, gpio_d;
  logic          can_q, can_d;
  logic [15:0]   udiv_q, udiv_d;
  logic [31:0]   ctb_q, ctb_d;
  sbl_item_type  tx_q, tx_d;
  logic          txV_q, txV_d;
  sbl_sram_type  sram_q, sram_d;
  logic          sramV_q, sramV_d;
  logic [31:0]   br_q, br_d;
  logic          go_q, go_d;
  logic          fail_q, fail_d;
  logic [63:0]   hdr;                    // Completed eight-byte header
  logic [31:0]   word;                   // Packed data word
  logic [21:0]   ids;                    // Expected rx and echo ids

  // Expected frame identifiers for a download phase
  function automatic logic [21:0] phaseIds(sbl_state_type s);
    case (s)
      ST_PWD:  phaseIds = {ID_PWD_RX, ID_PWD_TX};
      ST_ADDR: phaseIds = {ID_ADDR_RX, ID_ADDR_TX};
      default: phaseIds = {ID_DATA_RX, ID_DATA_TX};
    endcase
  endfunction

  // PLL multiplier from oscillator band
  function automatic logic [2:0] mulFor(logic [15:0] khz);
    if (khz < OSC_12M) begin
      mulFor = MUL_LOW;
    end else if (khz < OSC_16M) begin
      mulFor = MUL_MID;
    end else if (khz < OSC_24M) begin
      mulFor = MUL_HIGH;
    end else begin
      mulFor = MUL_TOP;
    end
  endfunction

  // Rx FIFO decouples controller from SRAM stalls
  sbl_fifo #(
    .WIDTH ($bits(sbl_item_type)),
    .DEPTH (FIFO_DEPTH)
  ) sbl_fifo_inst (
    .clk      (clk),
    .rst_n    (rst_n),
    .inData   (rxItem),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .outData  (fifoItem),
    .outValid (fifoValid),
    .outReady (pop)
  );

  // Next state of scan, measurement and download
  always_comb begin
    st_d = st_q; timer_d = timer_q; cnt_d = cnt_q; shift_d = shift_q;
    pack_d = pack_q; addr_d = addr_q; start_d = start_q; len_d = len_q;
    canLive_d = canLive_q; mul_d = mul_q; pll_d = pll_q; gpio_d = gpio_q;
    can_d = can_q; udiv_d = udiv_q; ctb_d = ctb_q; tx_d = tx_q;
    sram_d = sram_q; br_d = br_q; go_d = go_q; fail_d = fail_q;
    txV_d   = txV_q && !txReady;
    sramV_d = sramV_q && !sramReady;
    pop     = 1'b0;
    ids     = phaseIds(st_q);
    hdr     = {shift_q, fifoItem.data};
    word    = {pack_q, fifoItem.data} << {~cnt_q[1:0], 3'b000};
    case (st_q)
      ST_IDLE: begin
        if (bootCfg == CFG_AUTOBAUD) begin
          gpio_d = 1'b1;                               // see R09
          st_d   = ST_CLKMEAS;
        end else begin
          can_d = bootCfg != CFG_FIXED_UART;
          st_d  = ST_PWD;
        end
      end
      ST_CLKMEAS: begin
        if (oscValid) begin                            // see R13
          mul_d = mulFor(oscKhz);                      // see R15
          pll_d = 1'b1;                                // see R14
          st_d  = ST_PLLWAIT;
        end
      end
      ST_PLLWAIT: begin
        if (pllLocked) begin
          st_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        canLive_d = canRxPin;                          // see R10
        st_d      = ST_POLL;
      end
      ST_POLL: begin
        timer_d = '0;                                  // see R26
        if (canLive_q && !canRxPin) begin              // see R11
          can_d = 1'b1;
          st_d  = ST_MEAS;
        end else if (!uartRxPin) begin
          can_d = 1'b0;
          st_d  = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (can_q ? canRxPin : uartRxPin) begin        // see R20
          st_d = ST_DIVIDE;
        end else begin
          timer_d = timer_q + 1'b1;                    // see R12
        end
      end
      ST_DIVIDE: begin
        if (can_q) begin
          ctb_d = timer_q;
        end else begin
          udiv_d = 16'(timer_q / UART_DIV_STEP);       // see R25 R26
        end
        gpio_d = 1'b0;                                 // see R16
        st_d   = can_q ? ST_PWD : ST_ACK;              // see R17
      end
      ST_ACK: begin
        if (!txV_q) begin
          tx_d  = '{id: ID_PWD_TX, data: ACK_BYTE};    // see R21
          txV_d = 1'b1;
          st_d  = ST_PWD;
        end
      end
      ST_PWD, ST_ADDR, ST_DATA: begin
        if (fifoValid && !txV_q && !sramV_q) begin     // see R22
          pop     = 1'b1;
          txV_d   = 1'b1;
          tx_d    = '{id: ids[10:0], data: fifoItem.data}; // see R01 R02 R04
          cnt_d   = cnt_q + 1'b1;
          shift_d = hdr[55:0];                         // see R08 R23
          pack_d  = {pack_q[15:0], fifoItem.data};
          if (can_q && fifoItem.id != ids[21:11]) begin // see R24
            st_d = ST_FAIL;
          end else if (st_q == ST_PWD && cnt_q == HDR_LAST) begin
            cnt_d = '0;
            st_d  = (hdr == storedPassword) ? ST_ADDR : ST_FAIL; // see R01
          end else if (st_q == ST_ADDR && cnt_q == HDR_LAST) begin
            cnt_d   = '0;
            start_d = hdr[63:32];                      // see R02
            addr_d  = {hdr[63:34], 2'b00};
            len_d   = hdr[30:0];
            if (!hdr[FMT_POS]) begin                   // see R03
              st_d = ST_FAIL;
            end else begin
              st_d = (hdr[30:0] == '0) ? ST_DUMMY : ST_DATA;
            end
          end else if (st_q == ST_DATA) begin
            if (cnt_q[1:0] == 2'b11 || cnt_d == {1'b0, len_q}) begin
              sramV_d = 1'b1;
              sram_d  = '{addr: addr_q, data: word};   // see R05
              addr_d  = addr_q + 32'h0000_0004;        // see R06
            end
            if (cnt_d == {1'b0, len_q}) begin
              st_d = ST_DUMMY;
            end
          end
        end
      end
      ST_DUMMY: begin
        if (!sramV_q) begin
          sramV_d = 1'b1;
          sram_d  = '{addr: addr_q, data: 32'h0000_0000};
          st_d    = ST_BRANCH;
        end
      end
      ST_BRANCH: begin
        if (!sramV_q && !txV_q) begin
          br_d = {start_q[31:2], 2'b00};               // see R07
          go_d = 1'b1;
        end
      end
      default: begin
        fail_d = 1'b1;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE; timer_q <= '0; cnt_q <= '0; shift_q <= '0;
      pack_q <= '0; addr_q <= '0; start_q <= '0; len_q <= '0;
      canLive_q <= 1'b0; mul_q <= '0; pll_q <= 1'b0; gpio_q <= 1'b0;
      can_q <= 1'b0; udiv_q <= '0; ctb_q <= '0; tx_q <= '0;
      txV_q <= 1'b0; sram_q <= '0; sramV_q <= 1'b0; br_q <= '0;
      go_q <= 1'b0; fail_q <= 1'b0;
    end else begin
      st_q <= st_d; timer_q <= timer_d; cnt_q <= cnt_d; shift_q <= shift_d;
      pack_q <= pack_d; addr_q <= addr_d; start_q <= start_d; len_q <= len_d;
      canLive_q <= canLive_d; mul_q <= mul_d; pll_q <= pll_d; gpio_q <= gpio_d;
      can_q <= can_d; udiv_q <= udiv_d; ctb_q <= ctb_d; tx_q <= tx_d;
      txV_q <= txV_d; sram_q <= sram_d; sramV_q <= sramV_d; br_q <= br_d;
      go_q <= go_d; fail_q <= fail_d;
    end
  end

  // Outputs straight from registers
  assign pllMult     = mul_q;
  assign sysClkPll   = pll_q;
  assign rxPinGpio   = gpio_q;
  assign busCan      = can_q;
  assign uartDivisor = udiv_q;
  assign canTimeBase = ctb_q;
  assign txItem      = tx_q;
  assign txValid     = txV_q;
  assign sramWr      = sram_q;
  assign sramValid   = sramV_q;
  assign branchAddr  = br_q;
  assign branchGo    = go_q;
  assign bootFail    = fail_q;

  // Checks next to the logic
  pwd_echo_id_a: assert property (@(posedge clk) disable iff (!rst_n) // see R01
    pop && st_q == ST_PWD |=> txV_q && tx_q.id == ID_PWD_TX)
    else $error("password echo id wrong");
  addr_echo_id_a: assert property (@(posedge clk) disable iff (!rst_n) // see R02
    pop && st_q == ST_ADDR |=> txV_q && tx_q.id == ID_ADDR_TX)
    else $error("address echo id wrong");
  fmt_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // see R03
    pop && st_q == ST_ADDR && cnt_q == HDR_LAST && !shift_q[23] |=> st_q == ST_FAIL)
    else $error("format flag clear not refused");
  data_echo_a: assert property (@(posedge clk) disable iff (!rst_n) // see R04
    pop && st_q == ST_DATA |=> tx_q.id == ID_DATA_TX && tx_q.data == $past(fifoItem.data))
    else $error("data echo wrong");
  sram_align_a: assert property (@(posedge clk) disable iff (!rst_n) // see R05
    sramV_q |-> sram_q.addr[1:0] == 2'b00 && (!$past(sramV_q) || $stable(sram_q)))
    else $error("sram write misaligned or unstable");
  count_bound_a: assert property (@(posedge clk) disable iff (!rst_n) // see R06
    st_q == ST_DATA |-> cnt_q < {1'b0, len_q})
    else $error("byte count overrun");
  branch_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // see R07
    $rose(go_q) |-> br_q == {start_q[31:2], 2'b00} && !sramV_q && $past(st_q) == ST_BRANCH)
    else $error("branch address wrong");
  can_priority_a: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    st_q == ST_POLL && canLive_q && !canRxPin |=> can_q && st_q == ST_MEAS && timer_q == '0)
    else $error("CAN priority lost");
  pins_return_a: assert property (@(posedge clk) disable iff (!rst_n) // see R16
    st_q == ST_DIVIDE |=> !gpio_q ##0 (st_q == ST_PWD || st_q == ST_ACK))
    else $error("pins not returned");
  ack_byte_a: assert property (@(posedge clk) disable iff (!rst_n) // see R21
    st_q == ST_ACK && !txV_q |=> txV_q && tx_q.data == ACK_BYTE && st_q == ST_PWD)
    else $error("acknowledge byte wrong");
endmodule

// [inc/sbl_pkg.sv]
// Shared constants, states and carrier types of the serial boot loader
package sbl_pkg;
  // Frame identifiers per download phase: host to device, echo to host
  localparam logic [10:0] ID_PWD_RX  = 11'h011;
  localparam logic [10:0] ID_PWD_TX  = 11'h001;
  localparam logic [10:0] ID_ADDR_RX = 11'h012;
  localparam logic [10:0] ID_ADDR_TX = 11'h002;
  localparam logic [10:0] ID_DATA_RX = 11'h013;
  localparam logic [10:0] ID_DATA_TX = 11'h003;
  // Boot configuration pin codes
  localparam logic [1:0]  CFG_AUTOBAUD   = 2'h1;
  localparam logic [1:0]  CFG_FIXED_UART = 2'h2;
  // Acknowledge byte after UART rate setup
  localparam logic [7:0]  ACK_BYTE       = 8'h59;
  // Header phases carry eight bytes each
  localparam logic [31:0] HDR_LAST       = 32'h0000_0007;
  localparam int          FMT_POS        = 31;
  // Timer cycles per divisor step: 9 bits times 16 oversampling
  localparam logic [31:0] UART_DIV_STEP  = 32'h0000_0090;
  // Oscillator band edges in kHz and PLL multipliers
  localparam logic [15:0] OSC_8M         = 16'h1F40;
  localparam logic [15:0] OSC_12M        = 16'h2EE0;
  localparam logic [15:0] OSC_16M        = 16'h3E80;
  localparam logic [15:0] OSC_24M        = 16'h5DC0;
  localparam logic [2:0]  MUL_LOW        = 3'h4;
  localparam logic [2:0]  MUL_MID        = 3'h3;
  localparam logic [2:0]  MUL_HIGH       = 3'h2;
  localparam logic [2:0]  MUL_TOP        = 3'h1;
  // Rx FIFO depth
  localparam int          FIFO_DEPTH     = 32;
  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_CLKMEAS = 4'b0001,
    ST_PLLWAIT = 4'b0010,
    ST_SAMPLE  = 4'b0011,
    ST_POLL    = 4'b0100,
    ST_MEAS    = 4'b0101,
    ST_DIVIDE  = 4'b0110,
    ST_ACK     = 4'b0111,
    ST_PWD     = 4'b1000,
    ST_ADDR    = 4'b1001,
    ST_DATA    = 4'b1010,
    ST_DUMMY   = 4'b1011,
    ST_BRANCH  = 4'b1100,
    ST_FAIL    = 4'b1101
  } sbl_state_type;
  // One protocol byte with its frame identifier
  typedef struct packed {
    logic [10:0] id;
    logic [7:0]  data;
  } sbl_item_type;
  // One SRAM word write
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } sbl_sram_type;
endpackage

// [testbench/sbl_host_model.sv]
// Boot host model: feeds protocol bytes to the loader and collects its echoes
`timescale 1ns/1ps
module sbl_host_model (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Bytes toward the loader
  output sbl_pkg::sbl_item_type      rxItem,
  output logic                       rxValid,
  input  wire logic                  rxReady,
  // Echoes from the loader
  input  wire sbl_pkg::sbl_item_type txItem,
  input  wire logic                  txValid,
  output logic                       txReady
);
  import sbl_pkg::*;
  sbl_item_type sendQ [$];  // Bytes still to send, MSB first
  sbl_item_type echoQ [$];  // Every byte the loader sent back
  int           nTaken;     // Bytes accepted by the loader
  int           nEcho;      // Echoes of host bytes, the acknowledge excluded
  logic         burst;      // Send without waiting for each echo
  logic         hold;       // Stall the echo path

  initial begin
    rxValid = 1'b0;
    rxItem  = '0;
    txReady = 1'b0;
    clear();
  end

  // Forget all traffic before a new boot
  task automatic clear();
    sendQ.delete();
    echoQ.delete();
    nTaken = 0;
    nEcho  = 0;
    burst  = 1'b0;
    hold   = 1'b0;
  endtask

  // Handshakes are judged at the edge, new values land just after it
  always @(posedge clk) begin
    logic took;
    took = (rxValid & rxReady & rst_n) === 1'b1;
    if ((txValid & txReady) === 1'b1) begin
      echoQ.push_back(txItem);
      if (nTaken != 0) nEcho++;
    end
    #1;
    if (took) begin
      void'(sendQ.pop_front());
      nTaken++;
    end
    // Next byte only once the previous one came back, unless bursting
    if (sendQ.size() != 0 && (burst || nEcho >= nTaken)) begin
      rxValid = 1'b1;
      rxItem  = sendQ[0];
    end else begin
      rxValid = 1'b0;
      rxItem  = ~rxItem;  // Idle bus inverts the whole last item, id and data, every idle cycle, so it repeats on alternate cycles
    end
    txReady = !hold && ($urandom_range(3) != 0);
  end
endmodule

// [testbench/serial_boot_autobaud_loader_tb.sv]
// Self-checking bench of the serial boot loader
`timescale 1ns/1ps
module serial_boot_autobaud_loader_tb;
  import sbl_pkg::*;
  logic clk = 1'b0, rst_n, canRxPin, uartRxPin, oscValid, pllLocked;
  logic [1:0]   bootCfg;
  logic [15:0]  oscKhz, uartDivisor;
  logic [2:0]   pllMult;
  logic         sysClkPll, rxPinGpio, busCan, rxValid, rxReady, txValid, txReady;
  logic         sramValid, sramReady, branchGo, bootFail;
  logic [31:0]  canTimeBase, branchAddr, base;
  logic [63:0]  storedPassword;
  sbl_item_type rxItem, txItem;
  sbl_sram_type sramWr;
  sbl_sram_type sramQ [$];  // Captured SRAM writes
  sbl_item_type expQ [$];   // Expected echoes
  logic [7:0]   dat [$];    // Data bytes of the current download
  int           nMismatch = 0;
  int           checksDone = 0;
  int unsigned  seedUse;

  sbl_loader sbl_loader_inst (.clk(clk), .rst_n(rst_n), .bootCfg(bootCfg),
    .canRxPin(canRxPin), .uartRxPin(uartRxPin), .oscValid(oscValid), .oscKhz(oscKhz),
    .pllLocked(pllLocked), .pllMult(pllMult), .sysClkPll(sysClkPll),
    .rxPinGpio(rxPinGpio), .busCan(busCan), .uartDivisor(uartDivisor),
    .canTimeBase(canTimeBase), .rxItem(rxItem), .rxValid(rxValid), .rxReady(rxReady),
    .txItem(txItem), .txValid(txValid), .txReady(txReady),
    .storedPassword(storedPassword), .sramWr(sramWr), .sramValid(sramValid),
    .sramReady(sramReady), .branchAddr(branchAddr), .branchGo(branchGo),
    .bootFail(bootFail));
  sbl_host_model sbl_host_model_inst (.clk(clk), .rst_n(rst_n), .rxItem(rxItem),
    .rxValid(rxValid), .rxReady(rxReady), .txItem(txItem), .txValid(txValid),
    .txReady(txReady));

  // Clock of 4 ns
  always #2 clk = ~clk;

  // SRAM side: record writes, accept with random stalls
  always @(posedge clk) begin
    if ((sramValid & sramReady) === 1'b1) sramQ.push_back(sramWr);
    #1;
    sramReady = ($urandom_range(2) != 0);
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cmpVal(input string what, input logic [63:0] exp, input logic [63:0] got);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reportAndStop();
    $display("Mismatches %0d, comparisons %0d", nMismatch, checksDone);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    nMismatch++;
    $display("Error %s expected done seen timeout", what);
    reportAndStop();
  endtask

  task automatic waitLevel(ref logic sig, input logic val, input string what);
    for (int i = 0; i < 20000; i++) begin
      if (sig === val) return;
      step(1);
    end
    timeout(what);
  endtask

  // Reset with lines idle high, then check the reset outputs
  task automatic startup(input logic [1:0] cfg);
    rst_n = 1'b0;
    bootCfg = cfg;
    canRxPin = 1'b1;
    uartRxPin = 1'b1;
    oscValid = 1'b0;
    pllLocked = 1'b0;
    sbl_host_model_inst.clear();
    sramQ.delete();
    expQ.delete();
    step(12);
    rst_n = 1'b1;
    step(1);
    cmpVal("reset outputs", 64'h1, 64'({branchGo, bootFail, txValid, sramValid, rxReady}));
  endtask

  function automatic logic [10:0] echoId(input logic [10:0] id);
    return (id == ID_PWD_RX) ? ID_PWD_TX : (id == ID_ADDR_RX) ? ID_ADDR_TX : ID_DATA_TX;
  endfunction

  task automatic pushByte(input logic [10:0] id, input logic [7:0] b);
    sbl_host_model_inst.sendQ.push_back({id, b});
    expQ.push_back({echoId(id), b});
  endtask

  // Eight bytes, most significant first
  task automatic push64(input logic [10:0] id, input logic [63:0] v);
    for (int i = 7; i >= 0; i--) pushByte(id, v[8*i +: 8]);
  endtask

  task automatic pushData(input int len);
    dat.delete();
    for (int i = 0; i < len; i++) begin
      dat.push_back(8'($urandom));
      pushByte(ID_DATA_RX, dat[i]);
    end
  endtask

  task automatic waitEchoes();
    for (int i = 0; i < 20000 && sbl_host_model_inst.echoQ.size() < expQ.size(); i++) step(1);
    if (sbl_host_model_inst.echoQ.size() < expQ.size()) timeout("echo count");
  endtask

  // Echo compare: full item on CAN, data only on UART
  task automatic chkEchoes(input logic isCan);
    waitEchoes();
    foreach (expQ[i]) begin
      if (isCan) cmpVal("echo item", 64'(expQ[i]), 64'(sbl_host_model_inst.echoQ[i]));
      else cmpVal("echo byte", 64'(expQ[i].data), 64'(sbl_host_model_inst.echoQ[i].data));
    end
  endtask

  // Big-endian words with zero pad, then one dummy word, then the branch
  task automatic chkSram(input logic [31:0] a, input int len);
    int nw;
    logic [31:0] w;
    nw = (len + 3) / 4;
    cmpVal("sram word count", 64'(nw + 1), 64'(sramQ.size()));
    for (int k = 0; k <= nw && k < sramQ.size(); k++) begin
      w = '0;
      for (int j = 0; j < 4; j++) if (4*k + j < len) w[31-8*j -: 8] = dat[4*k + j];
      cmpVal("sram write", {a + 32'(4*k), w}, 64'(sramQ[k]));
    end
    cmpVal("branch address", 64'(a), 64'(branchAddr));
  endtask

  initial begin
    rst_n = 1'b0;
    bootCfg = 2'h0;
    oscKhz = 16'h0000;
    sramReady = 1'b0;
    seedUse = $urandom(32'h0000_BCDE);
    storedPassword = {$urandom, $urandom};
    // Fixed CAN boot, length that needs padding
    startup(2'h0);
    base = $urandom & 32'h0000_FFFC;
    push64(ID_PWD_RX, storedPassword);
    push64(ID_ADDR_RX, {base, 1'b1, 31'h0000_0005});
    pushData(5);
    waitLevel(branchGo, 1'b1, "branch");
    chkEchoes(1'b1);
    chkSram(base, 5);
    // UART autobaud with the FIFO filled until it refuses
    startup(CFG_AUTOBAUD);
    oscKhz = 16'h4E20;
    step(3);
    cmpVal("pins as GPIO", 64'h1, 64'(rxPinGpio));
    cmpVal("PLL before monitor", 64'h0, 64'(sysClkPll));
    oscValid = 1'b1;
    step(2);
    cmpVal("PLL multiplier", 64'(MUL_HIGH), 64'(pllMult));
    cmpVal("clock from PLL", 64'h1, 64'(sysClkPll));
    pllLocked = 1'b1;
    step(4);
    uartRxPin = 1'b0;
    step(300);
    uartRxPin = 1'b1;
    waitLevel(rxPinGpio, 1'b0, "UART measure");
    cmpVal("UART divisor", 64'(32'h0000_012C / UART_DIV_STEP), 64'(uartDivisor));
    cmpVal("bus is UART", 64'h0, 64'(busCan));
    expQ.push_back({ID_PWD_TX, ACK_BYTE});
    waitEchoes();
    cmpVal("ack byte", 64'(ACK_BYTE), 64'(sbl_host_model_inst.echoQ[0].data));
    push64(ID_PWD_RX, storedPassword);
    push64(ID_ADDR_RX, {base, 1'b1, 31'h0000_0026});
    waitEchoes();
    sbl_host_model_inst.burst = 1'b1;
    sbl_host_model_inst.hold = 1'b1;
    pushData(38);
    waitLevel(rxReady, 1'b0, "fifo full");
    // Refusal must stand while the echo path stays stalled
    step(5);
    cmpVal("rx refused", 64'h0, 64'(rxReady));
    sbl_host_model_inst.hold = 1'b0;
    waitLevel(branchGo, 1'b1, "UART branch");
    chkEchoes(1'b0);
    chkSram(base, 38);
    // CAN autobaud, both lines low together, wrong password
    startup(CFG_AUTOBAUD);
    oscKhz = 16'h1770;
    step(3);
    oscValid = 1'b1;
    pllLocked = 1'b1;
    step(2);
    cmpVal("PLL multiplier", 64'(MUL_LOW), 64'(pllMult));
    step(4);
    canRxPin = 1'b0;
    uartRxPin = 1'b0;
    step(100);
    canRxPin = 1'b1;
    uartRxPin = 1'b1;
    waitLevel(rxPinGpio, 1'b0, "CAN measure");
    cmpVal("CAN wins", 64'h1, 64'(busCan));
    cmpVal("CAN time base", 64'h1, 64'(canTimeBase >= 99 && canTimeBase <= 101));
    push64(ID_PWD_RX, ~storedPassword);
    waitLevel(bootFail, 1'b1, "password fail");
    cmpVal("no branch", 64'h0, 64'(branchGo));
    // Fixed UART boot with the format flag clear
    startup(CFG_FIXED_UART);
    cmpVal("fixed bus is UART", 64'h0, 64'(busCan));
    push64(ID_PWD_RX, storedPassword);
    push64(ID_ADDR_RX, {base, 1'b0, 31'h0000_0004});
    waitLevel(bootFail, 1'b1, "flag fail");
    cmpVal("no sram write", 64'h0, 64'(sramQ.size()));
    reportAndStop();
  end
endmodule
